// >>> rtl/link_cfg_defines.vh
`ifndef LINK_CFG_DEFINES_VH
`define LINK_CFG_DEFINES_VH
// register address pointer values (pointer bits 3:1)
`define REG_SEL_TWO 3'h2
`define REG_SEL_THREE 3'h3
`define REG_SEL_FOUR 3'h4
// config register two fields
`define CR2_SHORT_CYCLE 15
`define CR2_EXT_PRESCALER 14
`define CR2_GAP_TIMER_EN 12
`define CR2_JAPAN_EN 8
`define CR2_WMASK 16'hd1ff
// config register four fields
`define CR4_TX_WD_HI 15
`define CR4_TX_WD_LO 14
`define CR4_RX_WD_HI 13
`define CR4_RX_WD_LO 12
`define CR4_WM_HI 9
`define CR4_WM_LO 8
`define CR4_WMASK 16'hf3ff
`define CFG_RESET 16'h0000
// dma cycle lengths in system clocks
`define DMA_SHORT 3'h5
`define DMA_BURST 3'h6
`define DMA_SINGLE 3'h7
// primitive codes
`define PRIM_TX_WD 6'h03
`define PRIM_RX_WD 6'h04
`define PRIM_GAP 6'h05
// gap limit in poll timer periods
`define GAP_PERIODS 6'h20
// watchdog exponents
`define WD_EXP_BASE 18
`endif

// >>> rtl/link_ctrl_config_regs.v
// Summary of operation
// - short cycle bit gives 5-clock dma, else 6 burst or 7 single
// - extended prescaler bit picks 16-bit prescaler word, else legacy 8-bit
// - gap timer enable times gaps between received units, limit 32 poll periods
// - gap timer expiry issues primitive code 5
// - japan variant aligns using emergency status indication units only
// - japan variant activates five extra protocol timers, otherwise unused
// - japan variant error monitor; host swaps threshold and decrement fields
// - register two low byte holds address bits 23:16
// - register three holds address bits 15:0
// - tx and rx watchdogs independent, restart on each serial clock edge
// - watchdog expiry issues primitive 3 for tx, 4 for rx
// - select 00 off, 01 2^18, 10 2^19, 11 2^20 clocks
// - tx select bits 15:14, rx select bits 13:12 of register four
// - rx dma only when fifo holds watermark words or unit end seen
// - tx fetch only when fifo has room for watermark words
// - watermark 11=1, 10=9, 01=17, 00=25 words
// - primitive sets code and available flag, or lost flag if still set
`timescale 1ns/1ps
`include "link_cfg_defines.vh"
module link_ctrl_config_regs #(
    parameter FIFO_DEPTH_W = 6,
    parameter WD_W = 21
) (
    input wire clk,
    input wire resetn,
    input wire clk_en,
    input wire [2:0] register_address_pointer,
    input wire reg_write,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    input wire prim_flag_clear,
    output reg [5:0] provider_primitive_code,
    output reg primitive_available_flag,
    output reg primitive_lost_flag,
    input wire tx_serial_clock,
    input wire rx_serial_clock,
    input wire poll_timer_tick,
    input wire rx_unit_received,
    input wire dma_burst,
    output reg [2:0] dma_cycle_clocks,
    input wire [15:0] prescaler_word_16,
    input wire [7:0] prescaler_word_8,
    output reg [15:0] timer_prescale,
    output reg ext_prescaler_enable,
    output reg japan_variant_enable,
    output reg align_emergency_only,
    output reg variant_timers_active,
    output reg variant_error_monitor,
    output reg rx_unit_gap_timer_enable,
    output reg [23:0] init_block_address,
    input wire [FIFO_DEPTH_W-1:0] rx_fifo_words,
    input wire rx_unit_end,
    input wire [FIFO_DEPTH_W-1:0] tx_fifo_free,
    output reg rx_dma_ok,
    output reg tx_dma_ok
);

// things a user of this block should know:
// - reserved positions are masked at the write, so a careless host
//   cannot leave stray bits that later read back as set
// - reads are registered: the word for a pointer shows one clock after
//   the pointer is set, and a freshly written value two clocks after
// - a write to a pointer other than two, three or four is dropped
// - watchdog limits are fixed by the select code; there is no test
//   shortcut, so a full expiry takes at least a quarter million clocks
// - primitive sources are ranked tx watchdog, rx watchdog, gap timer;
//   a lower source that fires in the same clock is lost, not queued
// - all state holds still while clk_en is low, counters included
// - the flag clear and a new event in one clock: the event wins, so
//   the host never loses a primitive to its own clear
// - serial clocks pass two flip-flops before the edge detector, so a
//   restart lands about three clocks after the pin moves
// - the gap timer counts poll ticks, not clocks; a tick rate change
//   rescales the gap limit with it
// - mode outputs trail the configuration by one clock
// configuration images, reserved bits always zero
reg [15:0] cfg_two;
reg [15:0] cfg_three;
reg [15:0] cfg_four;
// serial clock synchronisers and edge history
reg [1:0] tx_sync;
reg [1:0] rx_sync;
reg tx_last;
reg rx_last;
reg [WD_W-1:0] tx_wd_count;
reg [WD_W-1:0] rx_wd_count;
reg tx_wd_fired;
reg rx_wd_fired;
reg [5:0] rx_unit_gap_timer;
reg gap_fired;
reg [5:0] watermark_words;
reg tx_wd_expire;
reg rx_wd_expire;
reg gap_expire;
reg prim_req;
reg [5:0] prim_code;

// watchdog limit from the two-bit select; zero means disabled
function [WD_W-1:0] wd_limit;
    input [1:0] sel;
    begin
        case (sel)
            2'h1: wd_limit = {{(WD_W-1){1'b0}}, 1'b1} << `WD_EXP_BASE;
            2'h2: wd_limit = {{(WD_W-1){1'b0}}, 1'b1} << (`WD_EXP_BASE + 1);
            2'h3: wd_limit = {{(WD_W-1){1'b0}}, 1'b1} << (`WD_EXP_BASE + 2);
            default: wd_limit = {WD_W{1'b0}};
        endcase
    end
endfunction

// watermark code to word count
always @* begin
    case (cfg_four[`CR4_WM_HI:`CR4_WM_LO])
        2'h3: watermark_words = 6'h01;
        2'h2: watermark_words = 6'h09;
        2'h1: watermark_words = 6'h11;
        default: watermark_words = 6'h19;
    endcase
end

// expiry detection; one event per quiet stretch
always @* begin
    tx_wd_expire = (cfg_four[`CR4_TX_WD_HI:`CR4_TX_WD_LO] != 2'h0) && !tx_wd_fired &&
        (tx_wd_count >= wd_limit(cfg_four[`CR4_TX_WD_HI:`CR4_TX_WD_LO]));
    rx_wd_expire = (cfg_four[`CR4_RX_WD_HI:`CR4_RX_WD_LO] != 2'h0) && !rx_wd_fired &&
        (rx_wd_count >= wd_limit(cfg_four[`CR4_RX_WD_HI:`CR4_RX_WD_LO]));
    gap_expire = cfg_two[`CR2_GAP_TIMER_EN] && !gap_fired &&
        (rx_unit_gap_timer >= `GAP_PERIODS);
end

// fixed priority when events coincide: tx, rx, gap; the others are dropped without setting lost
always @* begin
    prim_req = tx_wd_expire | rx_wd_expire | gap_expire;
    if (tx_wd_expire) begin
        prim_code = `PRIM_TX_WD;
    end else if (rx_wd_expire) begin
        prim_code = `PRIM_RX_WD;
    end else begin
        prim_code = `PRIM_GAP;
    end
end

// register file; reserved bits masked so they always read zero
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        cfg_two <= `CFG_RESET;
        cfg_three <= `CFG_RESET;
        cfg_four <= `CFG_RESET;
    end else if (clk_en && reg_write) begin
        case (register_address_pointer)
            `REG_SEL_TWO: cfg_two <= reg_wdata & `CR2_WMASK;
            `REG_SEL_THREE: cfg_three <= reg_wdata;
            `REG_SEL_FOUR: cfg_four <= reg_wdata & `CR4_WMASK;
            default: cfg_two <= cfg_two;
        endcase
    end
end

// read mux registered; unmapped pointer reads zero
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        reg_rdata <= 16'h0000;
    end else if (clk_en) begin
        case (register_address_pointer)
            `REG_SEL_TWO: reg_rdata <= cfg_two;
            `REG_SEL_THREE: reg_rdata <= cfg_three;
            `REG_SEL_FOUR: reg_rdata <= cfg_four;
            default: reg_rdata <= 16'h0000;
        endcase
    end
end

// tx serial clock: two-stage synchroniser, edge detected on the second stage
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        tx_sync <= 2'h0;
        tx_last <= 1'b0;
    end else if (clk_en) begin
        tx_sync <= {tx_sync[0], tx_serial_clock};
        tx_last <= tx_sync[1];
    end
end

// rx serial clock: same arrangement, kept apart so the two stay independent
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        rx_sync <= 2'h0;
        rx_last <= 1'b0;
    end else if (clk_en) begin
        rx_sync <= {rx_sync[0], rx_serial_clock};
        rx_last <= rx_sync[1];
    end
end

// tx watchdog; counter saturates, and the fired flag makes a dead clock fire only once
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        tx_wd_count <= {WD_W{1'b0}};
        tx_wd_fired <= 1'b0;
    end else if (clk_en) begin
        if (cfg_four[`CR4_TX_WD_HI:`CR4_TX_WD_LO] == 2'h0 || tx_sync[1] != tx_last) begin
            tx_wd_count <= {WD_W{1'b0}};
            tx_wd_fired <= 1'b0;
        end else begin
            if (tx_wd_count != {WD_W{1'b1}}) begin
                tx_wd_count <= tx_wd_count + 1'b1;
            end
            if (tx_wd_expire) begin
                tx_wd_fired <= 1'b1;
            end
        end
    end
end

// rx watchdog; own process so each select works on its own counter
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        rx_wd_count <= {WD_W{1'b0}};
        rx_wd_fired <= 1'b0;
    end else if (clk_en) begin
        if (cfg_four[`CR4_RX_WD_HI:`CR4_RX_WD_LO] == 2'h0 || rx_sync[1] != rx_last) begin
            rx_wd_count <= {WD_W{1'b0}};
            rx_wd_fired <= 1'b0;
        end else begin
            if (rx_wd_count != {WD_W{1'b1}}) begin
                rx_wd_count <= rx_wd_count + 1'b1;
            end
            if (rx_wd_expire) begin
                rx_wd_fired <= 1'b1;
            end
        end
    end
end

// gap timer counts poll periods since the last received unit
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        rx_unit_gap_timer <= 6'h00;
        gap_fired <= 1'b0;
    end else if (clk_en) begin
        if (!cfg_two[`CR2_GAP_TIMER_EN] || rx_unit_received) begin
            rx_unit_gap_timer <= 6'h00;
            gap_fired <= 1'b0;
        end else begin
            if (poll_timer_tick && rx_unit_gap_timer != 6'h3f) begin
                rx_unit_gap_timer <= rx_unit_gap_timer + 6'h01;
            end
            if (gap_expire) begin
                gap_fired <= 1'b1;
            end
        end
    end
end

// primitive reporting; a new event wins over a clear in the same cycle
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        provider_primitive_code <= 6'h00;
        primitive_available_flag <= 1'b0;
        primitive_lost_flag <= 1'b0;
    end else if (clk_en) begin
        if (prim_req && primitive_available_flag && !prim_flag_clear) begin
            primitive_lost_flag <= 1'b1;
        end else if (prim_req) begin
            provider_primitive_code <= prim_code;
            primitive_available_flag <= 1'b1;
            primitive_lost_flag <= 1'b0;
        end else if (prim_flag_clear) begin
            primitive_available_flag <= 1'b0;
            primitive_lost_flag <= 1'b0;
        end
    end
end

// dma cycle length; short cycle overrides both burst and single lengths
// burst is sampled each clock, so the length follows the dma in progress
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        dma_cycle_clocks <= `DMA_SINGLE;
    end else if (clk_en) begin
        if (cfg_two[`CR2_SHORT_CYCLE]) begin
            dma_cycle_clocks <= `DMA_SHORT;
        end else if (dma_burst) begin
            dma_cycle_clocks <= `DMA_BURST;
        end else begin
            dma_cycle_clocks <= `DMA_SINGLE;
        end
    end
end

// prescaler selection; legacy word zero-extended so timers see one width
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        ext_prescaler_enable <= 1'b0;
        timer_prescale <= 16'h0000;
    end else if (clk_en) begin
        ext_prescaler_enable <= cfg_two[`CR2_EXT_PRESCALER];
        if (cfg_two[`CR2_EXT_PRESCALER]) begin
            timer_prescale <= prescaler_word_16;
        end else begin
            timer_prescale <= {8'h00, prescaler_word_8};
        end
    end
end

// protocol mode flags; the variant bit fans out to every unit it changes
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        japan_variant_enable <= 1'b0;
        align_emergency_only <= 1'b0;
        variant_timers_active <= 1'b0;
        variant_error_monitor <= 1'b0;
        rx_unit_gap_timer_enable <= 1'b0;
    end else if (clk_en) begin
        japan_variant_enable <= cfg_two[`CR2_JAPAN_EN];
        align_emergency_only <= cfg_two[`CR2_JAPAN_EN];
        variant_timers_active <= cfg_two[`CR2_JAPAN_EN];
        variant_error_monitor <= cfg_two[`CR2_JAPAN_EN];
        rx_unit_gap_timer_enable <= cfg_two[`CR2_GAP_TIMER_EN];
    end
end

// init block address; the halves come from separate writes, so it is
// only consistent once the host has loaded both
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        init_block_address <= 24'h000000;
    end else if (clk_en) begin
        init_block_address <= {cfg_two[7:0], cfg_three};
    end
end

// watermark gates; unit end lets a short tail out without reaching the mark
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        rx_dma_ok <= 1'b0;
        tx_dma_ok <= 1'b0;
    end else if (clk_en) begin
        rx_dma_ok <= rx_unit_end || (rx_fifo_words >= watermark_words);
        tx_dma_ok <= tx_fifo_free >= watermark_words;
    end
end

endmodule // link_ctrl_config_regs

// >>> tb/link_host_model.sv
`timescale 1ns/1ps
module link_host_model (
    input wire clk,
    output logic [2:0] register_address_pointer = 3'h0,
    output logic reg_write = 1'b0,
    output logic [15:0] reg_wdata = 16'h0000
);
    // called at a falling edge; reserved bits go out as zero, init block word aligned
    task automatic wr(input logic [2:0] p, input logic [15:0] d);
        register_address_pointer = p;
        reg_write = 1'b1;
        reg_wdata = d & (p == 3'h2 ? 16'hd1ff : p == 3'h4 ? 16'hf3ff : 16'hfffe);
        @(negedge clk);
        reg_write = 1'b0;
        reg_wdata = ~reg_wdata; // idle bus never shows the old word
    endtask
endmodule // link_host_model

// >>> tb/link_ctrl_config_regs_assertions.sv
`timescale 1ns/1ps
module link_ctrl_config_regs_assertions #(parameter FIFO_DEPTH_W = 6) (
    input wire clk, input wire resetn, input wire clk_en, input wire [2:0] register_address_pointer,
    input wire reg_write, input wire [15:0] reg_wdata, input wire [15:0] reg_rdata,
    input wire [5:0] provider_primitive_code, input wire primitive_available_flag,
    input wire primitive_lost_flag, input wire dma_burst, input wire [2:0] dma_cycle_clocks,
    input wire [15:0] prescaler_word_16, input wire [7:0] prescaler_word_8,
    input wire [15:0] timer_prescale, input wire ext_prescaler_enable,
    input wire japan_variant_enable, input wire align_emergency_only,
    input wire variant_timers_active, input wire variant_error_monitor,
    input wire rx_unit_gap_timer_enable, input wire [23:0] init_block_address,
    input wire [FIFO_DEPTH_W-1:0] rx_fifo_words, input wire rx_unit_end,
    input wire [FIFO_DEPTH_W-1:0] tx_fifo_free, input wire rx_dma_ok, input wire tx_dma_ok
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn || !clk_en);
    reg [1:0] wm;
    reg sc;
    reg [15:0] wd1, wd2;
    wire [5:0] wm_n = wm == 2'h3 ? 6'h01 : wm == 2'h2 ? 6'h09 : wm == 2'h1 ? 6'h11 : 6'h19;
    wire [2:0] p = register_address_pointer;
    // shadows of the hidden config bits, so thresholds are known
    always @(posedge clk or negedge resetn) begin
        if (!resetn) {wm, sc} <= 3'h0;
        else if (clk_en && reg_write && p == 3'h4) wm <= reg_wdata[9:8];
        else if (clk_en && reg_write && p == 3'h2) sc <= reg_wdata[15];
    end
    // write data two edges back, when its effect shows
    always @(posedge clk) {wd2, wd1} <= {wd1, reg_wdata};
    dma_len_a: assert property (dma_cycle_clocks ==
        ($past(sc) ? 3'h5 : $past(dma_burst) ? 3'h6 : 3'h7)) else $error("dma length wrong");
    prescale_pick_a: assert property (timer_prescale == (ext_prescaler_enable ?
        $past(prescaler_word_16) : {8'h00, $past(prescaler_word_8)})) else $error("bad prescale");
    addr_low_a: assert property (reg_write && p == 3'h3 |-> ##2
        init_block_address[15:0] == wd2) else $error("low address wrong");
    addr_high_a: assert property (reg_write && p == 3'h2 |-> ##2
        init_block_address[23:16] == wd2[7:0]) else $error("high address wrong");
    mode_bits_a: assert property (reg_write && p == 3'h2 |-> ##2
        {ext_prescaler_enable, rx_unit_gap_timer_enable, japan_variant_enable,
        align_emergency_only, variant_timers_active, variant_error_monitor} ==
        {wd2[14], wd2[12], {4{wd2[8]}}}) else $error("mode bits wrong");
    resv_read_a: assert property ($past(p) == 3'h2 |-> !(reg_rdata & 16'h2e00))
        else $error("reserved bit read set");
    rx_gate_a: assert property (rx_dma_ok ==
        ($past(rx_unit_end) || $past(rx_fifo_words) >= $past(wm_n))) else $error("rx gate");
    tx_gate_a: assert property (tx_dma_ok == ($past(tx_fifo_free) >= $past(wm_n)))
        else $error("tx gate");
    lost_set_a: assert property ($rose(primitive_lost_flag) |-> primitive_available_flag &&
        $past(primitive_available_flag) && $stable(provider_primitive_code)) else $error("lost");
    gap_cov: cover property ($rose(primitive_available_flag) && provider_primitive_code == 6'h05);
    lost_cov: cover property ($rose(primitive_lost_flag));
    wm_cov: cover property (rx_dma_ok && !rx_unit_end);
endmodule // link_ctrl_config_regs_assertions
bind link_ctrl_config_regs link_ctrl_config_regs_assertions #(.FIFO_DEPTH_W(FIFO_DEPTH_W)) i_chk (.*);

// >>> tb/link_ctrl_config_regs_tb.sv
`timescale 1ns/1ps
module link_ctrl_config_regs_tb;
    logic clk = 0, resetn = 0, prim_flag_clear = 0, tx_serial_clock = 0, rx_serial_clock = 0;
    logic poll_timer_tick = 0, rx_unit_received = 0, dma_burst = 0, rx_unit_end = 0;
    logic [15:0] prescaler_word_16 = 0, reg_rdata, timer_prescale, reg_wdata;
    logic [7:0] prescaler_word_8 = 0;
    logic clk_en = 1;
    logic [5:0] rx_fifo_words = 0, tx_fifo_free = 0, provider_primitive_code;
    logic [2:0] register_address_pointer, dma_cycle_clocks;
    logic reg_write, primitive_available_flag, primitive_lost_flag, ext_prescaler_enable;
    logic japan_variant_enable, align_emergency_only, variant_timers_active;
    logic variant_error_monitor, rx_unit_gap_timer_enable, rx_dma_ok, tx_dma_ok;
    logic [23:0] init_block_address;
    logic [15:0] sh [0:7] = '{default: 16'h0000};
    wire [7:0] fl = {primitive_available_flag, primitive_lost_flag, provider_primitive_code};
    int n_errors = 0;
    int num_checks = 0;
    link_host_model i_link_host_model (.*);
    link_ctrl_config_regs i_link_ctrl_config_regs (.*);
    initial begin
        forever #5 clk = ~clk;
    end
    // serial clocks wander so the watchdogs keep restarting
    always @(negedge clk) if (resetn) {tx_serial_clock, rx_serial_clock} <= 2'($urandom);
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        if (n_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [5:0] wmn(input logic [1:0] w);
        wmn = w == 2'h3 ? 6'h01 : w == 2'h2 ? 6'h09 : w == 2'h1 ? 6'h11 : 6'h19;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // write, remember the stored image, wait until outputs show it
    task automatic wr(input logic [2:0] p, input logic [15:0] d);
        i_link_host_model.wr(p, d);
        sh[p] = d & (p == 3'h2 ? 16'hd1ff : p == 3'h3 ? 16'hfffe : p == 3'h4 ? 16'hf3ff : 16'h0);
        cyc(1);
    endtask
    task automatic ticks(input int n, input logic u);
        {rx_unit_received, prim_flag_clear} = {u, !u && n == 0};
        cyc(1);
        {rx_unit_received, prim_flag_clear} = 2'b00;
        repeat (n) begin
            poll_timer_tick = 1'b1;
            cyc(1);
            poll_timer_tick = 1'b0;
            cyc(1);
        end
        cyc(3);
    endtask
    initial begin
        #100us;
        n_errors++;
        end_sim();
    end
    initial begin
        logic [2:0] p;
        void'($urandom(14));
        cyc(2);
        resetn = 1'b1;
        cyc(1);
        chk({dma_cycle_clocks, fl, rx_dma_ok, tx_dma_ok}, {3'h7, 10'h000});
        chk(init_block_address, 24'h0);
        for (int i = 0; i < 24; i++) begin
            p = i < 8 ? 3'(i) : 3'($urandom_range(7, 0));
            wr(p, 16'($urandom));
            chk(reg_rdata, sh[p]);
            chk(init_block_address, {sh[2][7:0], sh[3]});
            chk({ext_prescaler_enable, rx_unit_gap_timer_enable, japan_variant_enable,
                align_emergency_only, variant_timers_active, variant_error_monitor},
                {sh[2][14], sh[2][12], {4{sh[2][8]}}});
        end
        for (int k = 0; k < 4; k++) begin
            dma_burst = k[0];
            prescaler_word_16 = 16'($urandom);
            prescaler_word_8 = 8'($urandom);
            wr(3'h2, {k[1], k[0], 14'h0});
            chk(dma_cycle_clocks, k[1] ? 3'h5 : k[0] ? 3'h6 : 3'h7);
            chk(timer_prescale, k[0] ? prescaler_word_16 : {8'h00, prescaler_word_8});
        end
        // each watermark just below, at, and below with unit end
        for (int w = 0; w < 4; w++) begin
            wr(3'h4, {4'($urandom), 2'h0, 2'(w), 8'h00});
            for (int e = 0; e < 3; e++) begin
                rx_fifo_words = wmn(2'(w)) - 6'(e != 1);
                tx_fifo_free = rx_fifo_words;
                rx_unit_end = e == 2;
                cyc(2);
                chk({rx_dma_ok, tx_dma_ok}, {e > 0, e == 1});
            end
        end
        // frozen clock enable: a write is dropped and the read word and init block address hold
        clk_en = 1'b0;
        i_link_host_model.wr(3'h3, 16'h1234);
        cyc(1);
        chk(reg_rdata, sh[4]);
        chk(init_block_address, {sh[2][7:0], sh[3]});
        clk_en = 1'b1;
        cyc(2);
        chk(reg_rdata, sh[3]);
        // quiet link: 31 periods silent, the 32nd reports the gap
        wr(3'h2, 16'h1000);
        ticks(0, 1'b0);
        ticks(31, 1'b1);
        chk(fl, 8'h00);
        ticks(1, 1'b0);
        chk(fl, 8'h85);
        ticks(32, 1'b1);
        chk(fl, 8'hc5);
        ticks(0, 1'b0);
        chk(fl[7:6], 2'b00);
        ticks(20, 1'b1);
        ticks(20, 1'b1);
        chk(fl[7:6], 2'b00);
        wr(3'h2, 16'h0000);
        ticks(40, 1'b1);
        chk(fl[7:6], 2'b00);
        end_sim();
    end
endmodule // link_ctrl_config_regs_tb
